// ### core/bcd_step.v
`timescale 1ns/100ps
`default_nettype none
`include "bcd_counter_defs.vh"

module bcd_step (
  input wire [`CNT_W-1:0] count_in,
  input wire count_down,
  output wire [`CNT_W-1:0] count_next
);

  // modulo-ten step; codes 10..15 after a preset fall back into range
  function [`CNT_W-1:0] bcd_next;
    input [`CNT_W-1:0] cur;
    input down;
    begin
      if (down) begin
        if (cur == `CNT_MIN || cur > `CNT_MAX) begin
          bcd_next = `CNT_MAX;
        end else begin
          bcd_next = cur - 4'h1;
        end
      end else begin
        if (cur >= `CNT_MAX) begin
          bcd_next = `CNT_MIN;
        end else begin
          bcd_next = cur + 4'h1;
        end
      end
    end
  endfunction

  assign count_next = bcd_next(count_in, count_down);

endmodule
`default_nettype wire

// ### core/bcd_updown_counter.v
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "bcd_counter_defs.vh"

module bcd_updown_counter (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire clock_pulse,
  input wire count_enable_n,
  input wire count_down,
  input wire preset_strobe_n,
  input wire [`CNT_W-1:0] preset_value,
  output wire [`CNT_W-1:0] count_value,
  output wire terminal_flag,
  output wire ripple_pulse_n
);

  ////////////////////////////////////////////////////////////////////
  // declarations

  reg [`CNT_W-1:0] count_ff;
  reg [`CNT_W-1:0] nxt_count;
  reg cp_prev_ff;
  reg ripple_low_ff;
  reg nxt_ripple_low;
  reg inhibit_ff;
  reg nxt_inhibit;
  reg [`STEPS_W-1:0] steps_ff;
  reg [`STEPS_W-1:0] nxt_steps;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;
  reg err_ff;
  reg nxt_err;
  wire [`CNT_W-1:0] step_value;
  wire preset_on;
  wire enable_n;
  wire cp_rise;
  wire cp_fall;
  wire count_step;
  wire apb_setup;
  wire apb_wr;
  wire apb_rd;
  wire hit_ctrl;
  wire hit_status;
  wire hit_steps;
  wire [31:0] status_word;

  ////////////////////////////////////////////////////////////////////
  // input edges and gating

  assign preset_on = ~preset_strobe_n;
  // software inhibit acts like holding the enable pin high
  assign enable_n = count_enable_n | inhibit_ff;
  // inputs are taken as synchronous, so a plain previous-sample compare will do
  assign cp_rise = clock_pulse & ~cp_prev_ff;
  assign cp_fall = ~clock_pulse & cp_prev_ff;
  // levels sampled only at the rise
  assign count_step = cp_rise & ~enable_n & ~preset_on;

  ////////////////////////////////////////////////////////////////////
  // count

  bcd_step u_step (
    .count_in(count_ff),
    .count_down(count_down),
    .count_next(step_value)
  );

  always @* begin
    nxt_count = count_ff;
    if (preset_on) begin
      nxt_count = preset_value;
    end else if (count_step) begin
      nxt_count = step_value;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= `CNT_RST;
      cp_prev_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      cp_prev_ff <= clock_pulse;
    end
  end

  // preset bypasses the clock
  // the bypass mux makes the count output combinational while the strobe is low
  assign count_value = preset_on ? preset_value : count_ff;

  ////////////////////////////////////////////////////////////////////
  // terminal flag and ripple

  // flag follows count and direction only
  // decoded, may glitch; never a clock
  terminal_decode u_term (
    .count_in(count_value),
    .count_down(count_down),
    .terminal(terminal_flag)
  );

  always @* begin
    nxt_ripple_low = ripple_low_ff;
    // low from fall until next rise
    if (cp_rise) begin
      nxt_ripple_low = 1'b0;
    end else if (cp_fall && !enable_n && terminal_flag) begin
      nxt_ripple_low = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ripple_low_ff <= 1'b0;
    end else begin
      ripple_low_ff <= nxt_ripple_low;
    end
  end

  assign ripple_pulse_n = ~(ripple_low_ff & terminal_flag & ~enable_n);

  ////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign hit_ctrl = (paddr == `OFS_CTRL);
  assign hit_status = (paddr == `OFS_STATUS);
  assign hit_steps = (paddr == `OFS_STEPS);

  assign status_word = {24'h00_0000, count_down, preset_on, ripple_pulse_n,
                        terminal_flag, count_value};

  always @* begin
    nxt_inhibit = inhibit_ff;
    if (apb_wr && hit_ctrl && pstrb[0]) begin
      nxt_inhibit = pwdata[`CTRL_INHIBIT];
    end
  end

  // a step in the same cycle as a clearing write survives as one
  always @* begin
    nxt_steps = steps_ff;
    if (apb_wr && hit_steps) begin
      nxt_steps = `STEPS_RST;
    end
    if (count_step) begin
      if (apb_wr && hit_steps) begin
        nxt_steps = 16'h0001;
      end else begin
        nxt_steps = steps_ff + 16'h0001;
      end
    end
  end

  // read data and error are registered in setup so they stand in access
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (apb_setup) begin
      if (hit_ctrl) begin
        nxt_rdata = {31'h0000_0000, inhibit_ff};
      end else if (hit_status) begin
        nxt_rdata = status_word;
        nxt_err = pwrite;
      end else if (hit_steps) begin
        nxt_rdata = {16'h0000, steps_ff};
      end else begin
        nxt_err = 1'b1;
      end
      if (pwrite) begin
        nxt_rdata = 32'h0000_0000;
      end
    end else if (psel && penable) begin
      nxt_rdata = rdata_ff;
      nxt_err = err_ff;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_ff <= 1'b0;
      steps_ff <= `STEPS_RST;
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else begin
      inhibit_ff <= nxt_inhibit;
      steps_ff <= nxt_steps;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end

  assign pready = 1'b1;
  assign prdata = apb_rd ? rdata_ff : 32'h0000_0000;
  assign pslverr = psel & penable & err_ff;

endmodule
`default_nettype wire

// ### core/terminal_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "bcd_counter_defs.vh"

module terminal_decode (
  input wire [`CNT_W-1:0] count_in,
  input wire count_down,
  output wire terminal
);

  assign terminal = count_down ? (count_in == `CNT_MIN) : (count_in == `CNT_MAX);

endmodule
`default_nettype wire

// ### pkg/bcd_counter_defs.vh
`ifndef BCD_COUNTER_DEFS_VH
`define BCD_COUNTER_DEFS_VH

// count layout
`define CNT_W 4
`define CNT_MAX 4'h9
`define CNT_MIN 4'h0
`define CNT_RST 4'h0

// apb register byte offsets
`define ADDR_W 12
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_STEPS 12'h008

// control fields
`define CTRL_INHIBIT 0
`define CTRL_RST 32'h0000_0000

// status fields
`define ST_CNT_LSB 0
`define ST_TERM 4
`define ST_RIPPLE_N 5
`define ST_PRESET 6
`define ST_DIR 7

// step counter
`define STEPS_W 16
`define STEPS_RST 16'h0000

`endif

// ### tb/bcd_updown_counter_props.sv
`timescale 1ns/100ps
`default_nettype none
module bcd_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clock_pulse,
  input wire logic count_enable_n,
  input wire logic count_down,
  input wire logic preset_strobe_n,
  input wire logic [3:0] preset_value,
  input wire logic [3:0] count_value,
  input wire logic terminal_flag,
  input wire logic ripple_pulse_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  property p_load; !preset_strobe_n |-> count_value == preset_value; endproperty
  a_load: assert property (p_load) else $error("preset not shown");
  property p_hold; preset_strobe_n && count_enable_n |=> !preset_strobe_n || $stable(count_value);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while disabled");
  property p_up; preset_strobe_n && !count_down && count_value <= 4'h9 ##1 preset_strobe_n
    && $changed(count_value) |-> count_value == (($past(count_value) == 4'h9) ? 4'h0
    : $past(count_value) + 4'h1); endproperty
  a_up: assert property (p_up) else $error("bad up step");
  property p_down; preset_strobe_n && count_down && count_value <= 4'h9 ##1 preset_strobe_n
    && $changed(count_value) |-> count_value == (($past(count_value) == 4'h0) ? 4'h9
    : $past(count_value) - 4'h1); endproperty
  a_down: assert property (p_down) else $error("bad down step");
  property p_term; terminal_flag == (count_down ? count_value == 4'h0 : count_value == 4'h9);
  endproperty
  a_term: assert property (p_term) else $error("terminal flag wrong");
  property p_rip_hi; count_enable_n || !terminal_flag |-> ripple_pulse_n; endproperty
  a_rip_hi: assert property (p_rip_hi) else $error("ripple low unasked");
  property p_rip_lo; !ripple_pulse_n |-> terminal_flag && !$past(clock_pulse); endproperty
  a_rip_lo: assert property (p_rip_lo) else $error("ripple low too early");
  property p_rip_end; !ripple_pulse_n && clock_pulse |=> ripple_pulse_n; endproperty
  a_rip_end: assert property (p_rip_end) else $error("ripple not ended");
  ////////////////////////////////////////
  c_wrap: cover property (count_value == 4'h9 && !count_down ##1 count_value == 4'h0);
  c_ripple: cover property ($fell(ripple_pulse_n));
  c_load: cover property ($fell(preset_strobe_n));
endmodule
bind bcd_updown_counter bcd_props u_bcd_props (.pclk, .presetn, .clock_pulse,
  .count_enable_n, .count_down, .preset_strobe_n, .preset_value, .count_value,
  .terminal_flag, .ripple_pulse_n);
`default_nettype wire

// ### tb/ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ctrl_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic slow,
  output logic clock_pulse
);
  logic [2:0] cnt_ff = 3'h0;
  always @(posedge pclk) begin
    if (cnt_ff != 3'h0)
      cnt_ff <= cnt_ff - 3'h1;
    else if (go)
      cnt_ff <= slow ? 3'h7 : 3'h3;
  end
  assign clock_pulse = cnt_ff > (slow ? 3'h3 : 3'h1);
endmodule
`default_nettype wire

// ### tb/test_bcd_updown_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "bcd_counter_defs.vh"
module test_bcd_updown_counter;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, slow = 0;
  logic count_enable_n = 0, count_down = 0, preset_strobe_n = 1, pready, pslverr, e;
  logic terminal_flag, ripple_pulse_n, clock_pulse;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, r;
  logic [3:0] preset_value = 0, count_value, x = 0;
  int error_cnt = 0, compares = 0, i;
  always #5 pclk = ~pclk;
  bcd_updown_counter u_bcd_updown_counter (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .clock_pulse,
    .count_enable_n, .count_down, .preset_strobe_n, .preset_value, .count_value,
    .terminal_flag, .ripple_pulse_n);
  ctrl_model u_ctrl_model (.pclk, .go, .slow, .clock_pulse);
  ////////////////////////////////////////
  function automatic logic [3:0] nxt(input logic [3:0] v, input logic d);
    nxt = d ? ((v == 4'h0 || v > 4'h9) ? 4'h9 : v - 4'h1) : (v >= 4'h9 ? 4'h0 : v + 4'h1);
  endfunction
  function automatic logic tf(input logic [3:0] v, input logic d);
    tf = d ? v == 4'h0 : v == 4'h9;
  endfunction
  task chk(input string n, input logic [3:0] s, input logic [3:0] v);
    compares++;
    if (s !== v) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", n, v, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task step;
    go <= 1;
    @(posedge pclk);
    go <= 0;
    repeat (10) @(posedge pclk);
  endtask
  task load(input logic [3:0] v);
    preset_value <= v;
    preset_strobe_n <= 0;
    step;
    chk("preset", count_value, v);
    preset_strobe_n <= 1;
    x = v;
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
  initial begin
    r = $urandom(33);
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("reset", count_value, 4'h0);
    for (i = 0; i < 40; i++) begin
      r = $urandom;
      if (r[6:4] == 3'h0) load(r[11:8]);
      count_enable_n <= r[0] & r[1];
      count_down <= r[2];
      slow <= r[3];
      if (!(r[0] & r[1])) x = nxt(x, r[2]);
      step;
      chk("count", count_value, x);
      chk("term", terminal_flag, tf(x, r[2]));
      chk("ripple", ripple_pulse_n, (r[0] & r[1]) | !tf(x, r[2]));
    end
    $display("random test done");
    count_enable_n <= 0;
    count_down <= 0;
    load(4'hc);
    step;
    chk("wrap", count_value, 4'h0);
    $display("corner test done");
    apb(1, `OFS_CTRL, 32'h1);
    apb(0, `OFS_CTRL, 0);
    chk("ctrl", q[3:0], 4'h1);
    step;
    chk("inhibit", count_value, 4'h0);
    apb(0, `OFS_STATUS, 0);
    chk("status", q[3:0], 4'h0);
    chk("status flags", q[7:4], 4'h2);
    apb(0, 12'h100, 0);
    chk("slverr", e, 4'h1);
    apb(1, `OFS_CTRL, 0);
    apb(1, `OFS_STEPS, 0);
    step;
    apb(0, `OFS_STEPS, 0);
    chk("steps", q[3:0], 4'h1);
    chk("count after", count_value, 4'h1);
    apb(1, `OFS_STATUS, 0);
    chk("status wr", e, 4'h1);
    $display("register test done");
    final_report;
  end
endmodule
`default_nettype wire
